// ### hw/fal_fifo.sv
// Parameterised valid/ready FIFO for converted samples
`timescale 1ns/1ps

module fal_fifo
  import fal_pkg::*;
#(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 32
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);

  // ==========================================================
  // State
  typedef struct packed {
    logic [AW-1:0] wr_ptr;   // Next slot to write
    logic [AW-1:0] rd_ptr;   // Next slot to read
    logic [AW:0]   count;    // Words held
  } fal_fifo_st_t;

  fal_fifo_st_t     st_reg;           // Registered pointers
  fal_fifo_st_t     st_next;          // Next pointers
  logic [WIDTH-1:0] mem [DEPTH];      // Storage array
  logic             push;             // Write this cycle
  logic             pop;              // Read this cycle

  // Honest flags straight from the count
  assign in_ready  = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data  = mem[st_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer and count update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.wr_ptr = st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'b1;
    end
    st_next.count = st_reg.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Storage has no reset; only valid words are ever read
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem[st_reg.wr_ptr] <= in_data;
    end
  end

endmodule // fal_fifo

// ### hw/fal_latch.sv
// Output latch stage of an 8-bit flash converter, with sample FIFO
`timescale 1ns/1ps

module fal_latch
  import fal_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Sample strobe, taken as synchronous to sys_clk
  input  wire logic       sample_strobe,
  // Quantised analog level and overrange comparator
  input  wire logic [7:0] analog_in_level,
  input  wire logic       analog_over_top,
  // Static coding select (1 enabled, 0 inhibited)
  input  wire logic       overrange_code_select_pin,
  // Latched parallel outputs
  output logic [7:0]      result_data,
  output logic            overrange_flag,
  // Sample stream through the FIFO
  output logic            smp_valid,
  input  wire logic       smp_ready,
  output logic [8:0]      smp_data,
  // Conversion refused because the FIFO was full
  output logic            smp_dropped
);

  // ==========================================================
  // State
  typedef struct packed {
    logic       strobe_prev;   // Strobe level one cycle ago
    fal_state_t phase;         // Pipeline fill state
    logic [7:0] pend_data;     // Conversion waiting for next edge
    logic       pend_ovr;      // Its overrange flag
    logic [7:0] out_data;      // Output latch, data
    logic       out_ovr;       // Output latch, flag
    logic       dropped;       // Sticky: a sample found the FIFO full
  } fal_st_t;

  fal_st_t    st_reg;          // Registered state
  fal_st_t    st_next;         // Next state
  logic       strobe_rise;     // Rising edge of the strobe
  logic [7:0] coded_data;      // Coded conversion result
  logic       coded_ovr;       // Coded overrange flag
  logic       fifo_push;       // Offer a result to the FIFO
  logic       fifo_in_ready;   // FIFO has room

  // ==========================================================
  // Overrange coding, one function so both paths agree
  function automatic logic [8:0] fal_code(input logic [7:0] lvl,
                                          input logic       over,
                                          input logic       mode);
    logic [8:0] r;
    r = {1'b0, lvl};
    if (over) begin
      if (mode == FAL_MODE_ENABLED) begin
        r = {1'b1, FAL_CODE_ZERO};
      end else begin
        r = {1'b0, FAL_CODE_FULL};
      end
    end
    return r;
  endfunction

  // Only a low-to-high step counts; falling edges are ignored
  assign strobe_rise = sample_strobe && !st_reg.strobe_prev;
  assign {coded_ovr, coded_data} =
    fal_code(analog_in_level, analog_over_top, overrange_code_select_pin);

  // ==========================================================
  // Next state
  always_comb begin
    st_next             = st_reg;
    st_next.strobe_prev = sample_strobe;
    if (strobe_rise) begin
      // Previous conversion moves to latches, new one is held
      st_next.out_data  = st_reg.pend_data;
      st_next.out_ovr   = st_reg.pend_ovr;
      st_next.pend_data = coded_data;
      st_next.pend_ovr  = coded_ovr;
      unique case (st_reg.phase)
        FAL_ST_IDLE:    st_next.phase = FAL_ST_PRIMED;
        FAL_ST_PRIMED:  st_next.phase = FAL_ST_RUNNING;
        FAL_ST_RUNNING: st_next.phase = FAL_ST_RUNNING;
        default:        st_next.phase = FAL_ST_IDLE;
      endcase
    end
    // Set wins over nothing: flag stays until reset
    if (fifo_push && !fifo_in_ready) begin
      st_next.dropped = 1'b1;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{strobe_prev: 1'b0, phase: FAL_ST_IDLE, pend_data: FAL_CODE_ZERO,
                  pend_ovr: FAL_OVR_RST, out_data: FAL_CODE_ZERO,
                  out_ovr: FAL_OVR_RST, dropped: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // Outputs straight from latch flip-flops; bit 7 is MSB, bit 0 LSB
  assign result_data    = st_reg.out_data;
  assign overrange_flag = st_reg.out_ovr;
  assign smp_dropped    = st_reg.dropped;

  // Only real results (after the first edge) enter the FIFO, word and flag together
  assign fifo_push = strobe_rise && (st_reg.phase != FAL_ST_IDLE);

  fal_fifo #(
    .WIDTH (FAL_DATA_W + 1),
    .DEPTH (FAL_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   ({st_reg.pend_ovr, st_reg.pend_data}),
    .out_valid (smp_valid),
    .out_ready (smp_ready),
    .out_data  (smp_data)
  );

  // ==========================================================
  // Assertions
  a_edge_loads: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (sample_strobe && !$past(sample_strobe)) |=>
      result_data == $past(st_reg.pend_data))
    else $error("latch not loaded on rising strobe");

  a_hold_between: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !strobe_rise |=> $stable(result_data) && $stable(overrange_flag))
    else $error("outputs moved without rising strobe");

  // Reference word coded straight from the pins at each rising strobe, kept apart
  // from the coding function so a fault there cannot hide from the latency check
  logic [8:0] lat_ref_q;       // Expected word of the most recent conversion
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_ref_q <= 9'h000;
    end else if (strobe_rise) begin
      if (!analog_over_top) begin
        lat_ref_q <= {1'b0, analog_in_level};
      end else if (overrange_code_select_pin) begin
        lat_ref_q <= 9'h100;
      end else begin
        lat_ref_q <= 9'h0ff;
      end
    end
  end

  // The word sampled at one rising strobe shows just after the next one
  a_one_cycle_lat: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (strobe_rise && st_reg.phase != FAL_ST_IDLE) |=>
      {overrange_flag, result_data} == $past(lat_ref_q))
    else $error("latency not one strobe cycle");

  a_enabled_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (strobe_rise && analog_over_top && overrange_code_select_pin) |=>
      st_reg.pend_ovr && st_reg.pend_data == FAL_CODE_ZERO)
    else $error("enabled overrange coding wrong");

  a_inhibit_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (strobe_rise && analog_over_top && !overrange_code_select_pin) |=>
      !st_reg.pend_ovr && st_reg.pend_data == FAL_CODE_FULL)
    else $error("inhibited overrange coding wrong");

  a_flag_needs_en: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (strobe_rise && !(analog_over_top && overrange_code_select_pin)) |=> !st_reg.pend_ovr)
    else $error("overrange flag without enabled overrange");

  a_in_range_pass: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (strobe_rise && !analog_over_top) |=>
      st_reg.pend_data[FAL_MSB_POS] == $past(analog_in_level[FAL_MSB_POS]) &&
      st_reg.pend_data[FAL_LSB_POS] == $past(analog_in_level[FAL_LSB_POS]))
    else $error("bit order of result wrong");

  a_fifo_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (fifo_push && fifo_in_ready) |=> u_fifo.out_valid)
    else $error("pushed sample not visible");

  c_enabled_over: cover property (@(posedge sys_clk) disable iff (!rst_n)
    strobe_rise && analog_over_top && overrange_code_select_pin);
  c_inhibit_over: cover property (@(posedge sys_clk) disable iff (!rst_n)
    strobe_rise && analog_over_top && !overrange_code_select_pin);
  c_fifo_full: cover property (@(posedge sys_clk) disable iff (!rst_n) !fifo_in_ready);
  c_back_to_back: cover property (@(posedge sys_clk) disable iff (!rst_n)
    strobe_rise ##2 strobe_rise);

endmodule // fal_latch

// ### inc/fal_pkg.sv
// Package of constants and types for the flash converter output latch
package fal_pkg;

  // ==========================================================
  // Data layout
  localparam int unsigned FAL_DATA_W     = 8;
  localparam int unsigned FAL_MSB_POS    = 7;
  localparam int unsigned FAL_LSB_POS    = 0;
  localparam int unsigned FAL_FIFO_DEPTH = 32;

  // ==========================================================
  // Reset values and fixed codes
  localparam logic [7:0] FAL_CODE_ZERO = 8'h00;
  localparam logic [7:0] FAL_CODE_FULL = 8'hff;
  localparam logic       FAL_OVR_RST   = 1'b0;

  // Overrange coding select: 1 = enabled (pin floats), 0 = inhibited (grounded)
  localparam logic FAL_MODE_ENABLED   = 1'b1;
  localparam logic FAL_MODE_INHIBITED = 1'b0;

  // ==========================================================
  // Latch state machine, Gray coded along idle -> primed -> running
  typedef enum logic [1:0] {
    FAL_ST_IDLE    = 2'b00,
    FAL_ST_PRIMED  = 2'b01,
    FAL_ST_RUNNING = 2'b11
  } fal_state_t;

endpackage : fal_pkg

// ### tb/fal_capture.sv
// Capture logic model that drains the latch's sample stream
`timescale 1ns/1ps

module fal_capture (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Sample stream from the latch
  input  wire logic       smp_valid,
  output logic            smp_ready,
  input  wire logic [8:0] smp_data,
  // Stall request from the testbench
  input  wire logic       stall
);
  logic [8:0] got[$];  // Words taken, in arrival order

  initial smp_ready = 1'b0;

  // ==========================================
  // Flag and data are taken as one word, only on an agreed edge
  always @(posedge sys_clk) begin
    if (rst_n && smp_valid && smp_ready) got.push_back(smp_data);
    // Ready moves just after the edge so the latch never sees a race
    smp_ready <= #2 rst_n && !stall;
  end
endmodule // fal_capture

// ### tb/testbench.sv
// Self-checking testbench for the flash converter output latch
`timescale 1ns/1ps

module testbench;
  import fal_pkg::*;
  // ==========================================
  // Stimulus, observed outputs and bookkeeping
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       sample_strobe = 1'b0;
  logic [7:0] analog_in_level = 8'h00;
  logic       analog_over_top = 1'b0;
  logic       mode_pin = FAL_MODE_ENABLED;
  logic [7:0] result_data;
  logic       overrange_flag, smp_valid, smp_ready, smp_dropped;
  logic [8:0] smp_data, prev, shown;
  logic [8:0] exp_q[$];  // Words the capture side should receive
  logic       stall = 1'b0;
  bit         have_prev = 0;
  bit         cap = 0;   // Set while the buffer is filled on purpose
  int         miscompares = 0;
  int         num_checks = 0;

  initial forever #12.5 sys_clk = ~sys_clk;

  fal_latch DUT (.sys_clk(sys_clk), .rst_n(rst_n), .sample_strobe(sample_strobe),
    .analog_in_level(analog_in_level), .analog_over_top(analog_over_top),
    .overrange_code_select_pin(mode_pin), .result_data(result_data),
    .overrange_flag(overrange_flag), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .smp_data(smp_data), .smp_dropped(smp_dropped));
  fal_capture capture (.sys_clk(sys_clk), .rst_n(rst_n), .smp_valid(smp_valid),
    .smp_ready(smp_ready), .smp_data(smp_data), .stall(stall));

  // ==========================================
  // Comparison, coding model and closing report
  task automatic chk(string what, logic [8:0] seen, logic [8:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [8:0] code(logic [7:0] lvl, logic ovr, logic mode);
    if (!ovr) return {1'b0, lvl};
    return (mode == FAL_MODE_ENABLED) ? {1'b1, FAL_CODE_ZERO} : {1'b0, FAL_CODE_FULL};
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One strobe rise, held hi cycles; then the previous sample must show
  task automatic pulse(logic [7:0] lvl, logic ovr, logic mode, int hi = 1);
    analog_in_level = lvl;
    analog_over_top = ovr;
    mode_pin = mode;
    sample_strobe = 1'b1;
    repeat (hi) @(posedge sys_clk);
    #2;
    analog_in_level = ~lvl;  // A falling edge must not take this
    sample_strobe = 1'b0;
    @(posedge sys_clk);
    #2;
    if (have_prev) begin
      chk("result", {overrange_flag, result_data}, prev);
      if (!cap || exp_q.size() < FAL_FIFO_DEPTH) exp_q.push_back(prev);
      shown = prev;
    end
    prev = code(lvl, ovr, mode);
    have_prev = 1;
  endtask

  // Wait for the capture side to catch up, then compare every word
  task automatic drain();
    int n;
    n = 0;
    while (capture.got.size() < exp_q.size()) begin
      @(posedge sys_clk);
      n++;
      if (n > 300) begin
        miscompares++;
        conclude();
      end
    end
    chk("count", 9'(capture.got.size()), 9'(exp_q.size()));
    foreach (exp_q[i]) chk("word", capture.got[i], exp_q[i]);
    capture.got.delete();
    exp_q.delete();
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    chk("reset out", {overrange_flag, result_data}, {FAL_OVR_RST, FAL_CODE_ZERO});
    chk("reset flags", {7'h00, smp_valid, smp_dropped}, 9'h000);
    $display("done reset");
  endtask

  task automatic t_enabled();
    pulse(8'h80, 1'b0, FAL_MODE_ENABLED);
    pulse(8'h01, 1'b0, FAL_MODE_ENABLED, 3);
    pulse(8'h5a, 1'b1, FAL_MODE_ENABLED);
    pulse(8'ha5, 1'b0, FAL_MODE_ENABLED);
    pulse(8'hff, 1'b1, FAL_MODE_ENABLED);
    $display("done enabled");
  endtask

  task automatic t_inhibit();
    pulse(8'h00, 1'b1, FAL_MODE_INHIBITED);
    pulse(8'h7f, 1'b0, FAL_MODE_INHIBITED);
    pulse(8'h3c, 1'b1, FAL_MODE_INHIBITED);
    pulse(8'h11, 1'b0, FAL_MODE_ENABLED);
    $display("done inhibit");
  endtask

  task automatic t_hold();
    repeat (5) begin
      @(posedge sys_clk);
      #2;
      analog_in_level = analog_in_level + 8'h11;
      chk("held", {overrange_flag, result_data}, shown);
    end
    drain();
    $display("done hold");
  endtask

  task automatic t_fill();
    stall = 1'b1;
    cap = 1;
    for (int i = 0; i < 33; i++) pulse(8'(i * 7), 1'b0, FAL_MODE_ENABLED);
    chk("full", {7'h00, smp_valid, smp_dropped}, 9'h003);
    stall = 1'b0;
    drain();
    cap = 0;
    $display("done fill");
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    #2;
    t_reset();
    rst_n = 1'b1;
    t_enabled();
    t_inhibit();
    t_hold();
    t_fill();
    conclude();
  end
endmodule // testbench
